// >>> shared/bit_io_pkg.sv
// Constants and types shared by the single-bit I/O access block
package bit_io_pkg;
   localparam int unsigned ADDR_W        = 15;
   localparam int unsigned BASE_W        = 16;
   localparam int unsigned DISP_W        = 8;
   localparam int unsigned EQ_BIT        = 2;
   localparam int unsigned STATUS_W      = 16;
   localparam int unsigned BASE_LSB      = 0;
   localparam int unsigned BASE_MSB      = 14;
   localparam int unsigned ACCESS_CYCLES = 2;

   typedef enum logic [1:0]
   {
      OP_CLEAR = 2'h0,
      OP_SET   = 2'h1,
      OP_TEST  = 2'h2,
      OP_NONE  = 2'h3
   } bit_op_t;
endpackage

// >>> hw/bit_addr_adder.sv
// Bit address former: base bits plus sign-extended displacement
`timescale 1ns/1ps
module bit_addr_adder
   import bit_io_pkg::*;
(
   // Operands
   input  wire logic [bit_io_pkg::BASE_W-1:0] base,
   input  wire logic [bit_io_pkg::DISP_W-1:0] disp,
   // Result
   output logic      [bit_io_pkg::ADDR_W-1:0] addr
);
   logic [ADDR_W-1:0] disp_ext;

   always_comb
   begin
      disp_ext = {{(ADDR_W-DISP_W){disp[DISP_W-1]}}, disp};
      // Top base bit dropped; sum wraps in the 15-bit space
      addr = base[BASE_MSB:BASE_LSB] + disp_ext;
   end
endmodule

// >>> hw/single_bit_io.sv
// Single-bit clear, set and test accesses to the bit I/O space
//
// Overview of operation
// - Clear-bit drives serial_bit_out low at the computed bit address.
// - Set-bit drives serial_bit_out high at the computed bit address.
// - Test-bit samples serial_bit_in into status bit 2, the equal flag.
// - Clear and set pulse the output strobe; test pulses the input strobe.
// - Each operation takes one operand: an eight-bit displacement.
// - Displacement is sign-extended, range -128 to +127.
// - Address is base bits 0..14 plus displacement, driven on address lines.
// - After test, equal means jump-if-equal taken, else jump-if-not-equal.
// - Base register bit 15 never reaches the bit address.
// - Bit address is 15 bits: 32768 inputs and 32768 outputs.
`timescale 1ns/1ps
module single_bit_io
   import bit_io_pkg::*;
(
   // Clock and reset
   input  wire logic                            clk,
   input  wire logic                            resetn,
   // Operation request
   input  wire logic                            op_valid,
   input  wire bit_io_pkg::bit_op_t             op_code,
   input  wire logic [bit_io_pkg::DISP_W-1:0]   op_disp,
   input  wire logic [bit_io_pkg::BASE_W-1:0]   bit_base_register,
   output logic                                 op_ready,
   output logic                                 op_done,
   // Bit I/O space pins
   output logic [bit_io_pkg::ADDR_W-1:0]        bit_addr,
   output logic                                 serial_bit_out,
   output logic                                 out_strobe,
   output logic                                 in_strobe,
   input  wire logic                            serial_bit_in,
   // Status
   output logic                                 equal_flag,
   output logic                                 jump_if_equal,
   output logic                                 jump_if_not_equal
);
   typedef enum logic [1:0]
   {
      ST_IDLE   = 2'h0,
      ST_ACCESS = 2'h1,
      ST_DONE   = 2'h2
   } state_t;

   localparam logic [1:0] CNT_LAST = 2'(ACCESS_CYCLES - 1);

   // Counter is two bits; a longer access needs a wider counter
   if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 4)
   begin : g_bad_access
      $error("Access length does not fit the two-bit counter");
   end

   // Base field must fill the bit address exactly
   if (BASE_MSB - BASE_LSB + 1 != ADDR_W)
   begin : g_bad_base_field
      $error("Base field width differs from the bit address width");
   end

   // Sign extension needs at least one copied sign bit
   if (DISP_W >= ADDR_W)
   begin : g_bad_disp
      $error("Displacement is not narrower than the bit address");
   end

   // Base field must lie inside the base register
   if (BASE_MSB >= BASE_W)
   begin : g_bad_base_reg
      $error("Base field reaches past the base register");
   end

   // Equal flag must lie inside the status word
   if (EQ_BIT >= STATUS_W)
   begin : g_bad_status
      $error("Equal flag position outside the status word");
   end

   logic [ADDR_W-1:0] sum_addr;
   logic              in_meta_q;
   logic              in_sync_q;
   state_t            state_q, state_d;
   logic [1:0]        cnt_q, cnt_d;
   bit_op_t           op_q, op_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic              out_q, out_d;
   logic              ostb_q, ostb_d;
   logic              istb_q, istb_d;
   logic              eq_q, eq_d;
   // Own flop so the inverse jump output is a clean register
   logic              neq_q, neq_d;
   logic              ready_q, ready_d;
   logic              done_q, done_d;

   // Single operand only: displacement plus current base
   bit_addr_adder u_adder
   (
      .base (bit_base_register),
      .disp (op_disp),
      .addr (sum_addr)
   );

   // Pin input is from another domain; two stages before use
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         in_meta_q <= 1'b0;
         in_sync_q <= 1'b0;
      end
      else
      begin
         in_meta_q <= serial_bit_in;
         in_sync_q <= in_meta_q;
      end
   end

   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      op_d    = op_q;
      addr_d  = addr_q;
      out_d   = out_q;
      ostb_d  = ostb_q;
      istb_d  = istb_q;
      eq_d    = eq_q;
      neq_d   = neq_q;
      ready_d = ready_q;
      done_d  = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            if (op_valid && op_code != OP_NONE)
            begin
               op_d    = op_code;
               addr_d  = sum_addr;
               ready_d = 1'b0;
               cnt_d   = 2'h0;
               state_d = ST_ACCESS;
               if (op_code == OP_TEST)
               begin
                  istb_d = 1'b1;
               end
               else
               begin
                  ostb_d = 1'b1;
                  out_d  = (op_code == OP_SET);
               end
            end
         end
         ST_ACCESS:
         begin
            // Address and data held for the whole strobe
            if (cnt_q == CNT_LAST)
            begin
               if (op_q == OP_TEST)
               begin
                  eq_d = in_sync_q;
                  neq_d = ~in_sync_q;
               end
               ostb_d  = 1'b0;
               istb_d  = 1'b0;
               state_d = ST_DONE;
            end
            else
            begin
               cnt_d = cnt_q + 2'h1;
            end
         end
         ST_DONE:
         begin
            done_d  = 1'b1;
            ready_d = 1'b1;
            state_d = ST_IDLE;
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_q <= ST_IDLE;
         cnt_q   <= 2'h0;
         op_q    <= OP_NONE;
         addr_q  <= '0;
         out_q   <= 1'b0;
         ostb_q  <= 1'b0;
         istb_q  <= 1'b0;
         eq_q    <= 1'b0;
         neq_q   <= 1'b1;
         ready_q <= 1'b1;
         done_q  <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         op_q    <= op_d;
         addr_q  <= addr_d;
         out_q   <= out_d;
         ostb_q  <= ostb_d;
         istb_q  <= istb_d;
         eq_q    <= eq_d;
         neq_q   <= neq_d;
         ready_q <= ready_d;
         done_q  <= done_d;
      end
   end

   assign op_ready          = ready_q;
   assign op_done           = done_q;
   assign bit_addr          = addr_q;
   assign serial_bit_out    = out_q;
   assign out_strobe        = ostb_q;
   assign in_strobe         = istb_q;
   assign equal_flag        = eq_q;
   assign jump_if_equal     = eq_q;
   assign jump_if_not_equal = neq_q;
endmodule

// >>> bench/single_bit_io_properties.sv
// Port checks for the single-bit I/O access block
`timescale 1ns/1ps
module single_bit_io_properties
   import bit_io_pkg::*;
(
   // Clock, reset and request
   input wire logic             clk,
   input wire logic             resetn,
   input wire logic             op_valid,
   input wire bit_io_pkg::bit_op_t op_code,
   input wire logic [7:0]       op_disp,
   input wire logic [15:0]      bit_base_register,
   input wire logic             op_ready,
   input wire logic             op_done,
   // Bit space and status
   input wire logic [14:0]      bit_addr,
   input wire logic             serial_bit_out,
   input wire logic             out_strobe,
   input wire logic             in_strobe,
   input wire logic             equal_flag,
   input wire logic             jump_if_equal,
   input wire logic             jump_if_not_equal,
   input wire logic             serial_bit_in
);
   logic [14:0] exp_q;
   wire         take = op_valid && op_ready && (op_code != OP_NONE);
   // 15-bit sum wraps by width
   always_ff @(posedge clk)
   begin
      if (take)
         exp_q <= bit_base_register[14:0] + {{7{op_disp[7]}}, op_disp};
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_clear_low: assert property (take && op_code == OP_CLEAR
      |=> !serial_bit_out) else $error("clear did not drive 0");
   a_set_high: assert property (take && op_code == OP_SET
      |=> serial_bit_out) else $error("set did not drive 1");
   a_test_in_strobe: assert property (take && op_code == OP_TEST
      |=> in_strobe && !out_strobe) else $error("test strobe wrong");
   a_out_strobe_two: assert property (take && op_code != OP_TEST
      |=> out_strobe[*2] ##1 !out_strobe) else $error("out strobe wrong");
   a_done_latency: assert property (take
      |=> !op_ready[*3] ##1 (op_ready && op_done)) else $error("done late");
   a_addr_formed: assert property (take
      |=> bit_addr == exp_q) else $error("bit address wrong");
   a_addr_held: assert property (out_strobe && $past(out_strobe)
      |-> $stable(bit_addr) && $stable(serial_bit_out))
      else $error("address moved in access");
   a_flag_kept: assert property (out_strobe
      |=> $stable(equal_flag)) else $error("flag moved on output");
   a_test_flag_in: assert property (take && op_code == OP_TEST
      |=> ##2 equal_flag == $past(serial_bit_in, 3))
      else $error("test result not in flag");
   a_jump_follows: assert property (
      jump_if_equal == equal_flag && jump_if_not_equal != equal_flag)
      else $error("jump outputs disagree with flag");
   c_clear: cover property (take && op_code == OP_CLEAR);
   c_set: cover property (take && op_code == OP_SET);
   c_test: cover property (take && op_code == OP_TEST);
endmodule

// >>> bench/bit_periph_model.sv
// Bit-addressed peripheral: output latch and one input line
`timescale 1ns/1ps
module bit_periph_model
(
   input  wire logic        clk,
   input  wire logic [14:0] bit_addr,
   input  wire logic        serial_bit_out,
   input  wire logic        out_strobe,
   input  wire logic        in_value,
   output logic             serial_bit_in,
   output logic [14:0]      wr_addr,
   output logic             wr_bit
);
   always_ff @(posedge clk)
   begin
      if (out_strobe)
      begin
         wr_addr <= bit_addr;
         wr_bit  <= serial_bit_out;
      end
   end
   // Held for the whole access, so the synchroniser sees it settled
   assign serial_bit_in = in_value;
endmodule

// >>> bench/single_bit_io_bench.sv
// Self-checking bench for the single-bit I/O access block
`timescale 1ns/1ps
module single_bit_io_bench;
   import bit_io_pkg::*;
   logic        clk = 1'b0, resetn = 1'b0, op_valid = 1'b0, in_value = 1'b0;
   bit_op_t     op_code = OP_NONE;
   logic [7:0]  op_disp = 8'h00;
   logic [15:0] base = 16'h0000;
   logic        op_ready, op_done, serial_bit_out, out_strobe, in_strobe;
   logic        serial_bit_in, equal_flag, jump_if_equal, jump_if_not_equal;
   logic        wr_bit, exp_eq = 1'b0;
   logic [14:0] bit_addr, wr_addr;
   int          error_cnt = 0, n_compared = 0, exp_addr;
   always #2.5 clk = ~clk;
   single_bit_io u_single_bit_io (.clk(clk), .resetn(resetn),
      .op_valid(op_valid), .op_code(op_code), .op_disp(op_disp),
      .bit_base_register(base), .op_ready(op_ready), .op_done(op_done),
      .bit_addr(bit_addr), .serial_bit_out(serial_bit_out),
      .out_strobe(out_strobe), .in_strobe(in_strobe),
      .serial_bit_in(serial_bit_in), .equal_flag(equal_flag),
      .jump_if_equal(jump_if_equal), .jump_if_not_equal(jump_if_not_equal));
   bit_periph_model u_bit_periph_model (.clk(clk), .bit_addr(bit_addr),
      .serial_bit_out(serial_bit_out), .out_strobe(out_strobe),
      .in_value(in_value), .serial_bit_in(serial_bit_in),
      .wr_addr(wr_addr), .wr_bit(wr_bit));
   task automatic check(input logic [15:0] seen, exp, input string what);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      if (error_cnt == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic run_op(input bit_op_t c, input logic [7:0] d,
                         input logic [15:0] b, input logic v);
      int n;
      @(negedge clk);
      in_value = v;
      repeat (2) @(negedge clk);
      op_code = c;
      op_disp = d;
      base = b;
      op_valid = 1'b1;
      @(negedge clk);
      op_valid = 1'b0;
      for (n = 0; n < 10 && op_done !== 1'b1; n++)
         @(negedge clk);
      if (n == 10)
      begin
         error_cnt++;
         final_report();
      end
      exp_addr = (int'(b[14:0]) + int'($signed(d))) & 32'h7FFF;
      check(16'(bit_addr), 16'(exp_addr), "addr");
      if (c == OP_TEST)
         exp_eq = v;
      else
         check({wr_bit, wr_addr}, {c == OP_SET, exp_addr[14:0]},
               "out");
      check(16'({jump_if_not_equal, jump_if_equal, equal_flag}),
            16'({~exp_eq, exp_eq, exp_eq}), "flag");
   endtask
   initial
   begin
      void'($urandom(32366));
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      check(16'({op_ready, op_done, jump_if_not_equal}), 16'h5, "reset");
      run_op(OP_TEST, 8'h80, 16'h8000, 1'b1);
      run_op(OP_SET, 8'h01, 16'h7FFF, 1'b0);
      run_op(OP_CLEAR, 8'h7F, 16'hFFFF, 1'b1);
      op_valid = 1'b1;
      op_code = OP_NONE;
      repeat (4) @(negedge clk);
      check(16'({op_ready, op_done, out_strobe, in_strobe}), 16'h8,
            "none");
      op_valid = 1'b0;
      repeat (40)
         run_op(bit_op_t'($urandom_range(2)), 8'($urandom), 16'($urandom),
                1'($urandom));
      run_op(OP_TEST, 8'h00, 16'h0000, 1'b1);
      resetn = 1'b0;
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      exp_eq = 1'b0;
      check(16'({op_ready, equal_flag, jump_if_not_equal}), 16'h5,
            "mid reset");
      run_op(OP_SET, 8'hFF, 16'h0000, 1'b0);
      final_report();
   end
endmodule
bind single_bit_io single_bit_io_properties u_props (.clk(clk),
   .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
   .op_disp(op_disp), .bit_base_register(bit_base_register),
   .op_ready(op_ready), .op_done(op_done), .bit_addr(bit_addr),
   .serial_bit_out(serial_bit_out), .out_strobe(out_strobe),
   .in_strobe(in_strobe), .equal_flag(equal_flag),
   .jump_if_equal(jump_if_equal), .jump_if_not_equal(jump_if_not_equal),
   .serial_bit_in(serial_bit_in));
